// *** pls_pkg.sv ***
/*
  Package for the tuner synthesizer block: port channel codes, field
  positions, reset values, reference divide ratios and gate timing.
  Assumes a 100 MHz ref_clk standing in for the 7.2 MHz crystal time base.
*/
package pls_pkg;

  // ==========================================================
  // Clock
  // ==========================================================
  localparam int CLK_HZ = 100_000_000;

  // ==========================================================
  // Port channel codes (output side, PLL output instruction)
  // ==========================================================
  localparam logic [3:0] CH_OUT_MODE    = 4'h0;
  localparam logic [3:0] CH_OUT_DIV0    = 4'h1;
  localparam logic [3:0] CH_OUT_DIV1    = 4'h2;
  localparam logic [3:0] CH_OUT_DIV2    = 4'h3;
  localparam logic [3:0] CH_OUT_DIV3    = 4'h4;
  localparam logic [3:0] CH_OUT_REF     = 4'h5;
  localparam logic [3:0] CH_OUT_IFCTL_A = 4'h6;
  localparam logic [3:0] CH_OUT_IFCTL_B = 4'h7;

  // Input side channel codes
  localparam logic [3:0] CH_IN_CNT0   = 4'h1;
  localparam logic [3:0] CH_IN_CNT4   = 4'h5;
  localparam logic [3:0] CH_IN_STATUS = 4'h6;
  localparam logic [3:0] CH_IN_UNLOCK = 4'h7;

  // ==========================================================
  // Field positions
  // ==========================================================
  localparam int MODE_HIGH_BAND = 0;
  localparam int MODE_OFS_PLUS  = 1;
  localparam int MODE_OFS_MINUS = 2;
  localparam int MODE_VHF_BAND  = 3;
  localparam int CTLA_GATE0     = 0;
  localparam int CTLA_GATE1     = 1;
  localparam int CTLA_MANUAL    = 2;
  localparam int CTLA_GO        = 3;
  localparam int CTLB_INCTL_A   = 0;
  localparam int CTLB_INCTL_B   = 1;
  localparam int CTLB_IF_CHOICE = 2;
  localparam int CTLB_UNLK_RST  = 3;
  localparam int STAT_BUSY      = 0;
  localparam int STAT_OVF       = 1;
  localparam int UNLK_FLAG      = 2;
  localparam int UNLK_TEST_EN   = 3;

  // ==========================================================
  // Reset values
  // ==========================================================
  localparam logic [3:0] REF_PLL_OFF  = 4'hF;
  localparam logic [3:0] REF_RESET    = 4'hF;
  localparam logic [1:0] INCTL_RESET  = 2'h0;
  localparam logic       IF_CH_RESET  = 1'b1;
  localparam logic [1:0] SEL_DIRECT   = 2'h0;
  localparam logic [1:0] SEL_BOTH     = 2'h3;

  // ==========================================================
  // Reference frequencies in mHz and divide ratios
  // ==========================================================
  localparam int REF_CODES = 10;
  localparam int DIVW      = 20;
  typedef int ref_tab_type [REF_CODES];
  localparam ref_tab_type REF_MHZ = '{1_000_000, 50_000_000, 5_000_000,
                                      100_000_000, 9_000_000, 10_000_000,
                                      12_500_000, 25_000_000, 3_125_000,
                                      6_250_000};

  function automatic logic [DIVW-1:0] pls_ref_half(input logic [3:0] code);
    longint q;
    q = 64'd0;
    if (code < 4'hA) begin
      q = (64'(CLK_HZ) * 64'd1000) / (64'd2 * 64'(REF_MHZ[code]));
    end
    return q[DIVW-1:0];
  endfunction : pls_ref_half

  // ==========================================================
  // Gate times (ms) and derived cycle counts
  // ==========================================================
  localparam int GATE_MS_0 = 1;
  localparam int GATE_MS_1 = 4;
  localparam int GATE_MS_2 = 8;
  localparam int GATE_MS_3 = 16;
  localparam int CYC_PER_MS = CLK_HZ / 1000;

  typedef enum logic [1:0] {
    PLS_IDLE  = 2'b00,
    PLS_COUNT = 2'b01,
    PLS_DONE  = 2'b11
  } pls_if_state_type;

endpackage : pls_pkg

// *** pls_prog_div.sv ***
/*
  Programmable divider: dual-modulus prescaler with swallow counter and
  12-bit main counter, or direct 12-bit division.
  Assumes the divider input is an event pulse synchronous to ref_clk.
*/
`timescale 1ns/1ps
module pls_prog_div
  import pls_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  // Control
  input  wire logic        run,
  input  wire logic        dual_mod,
  input  wire logic        pre_half,
  input  wire logic [15:0] div_n,
  // Data
  input  wire logic        in_pulse,
  output logic             div_out
);

  typedef struct packed {
    logic        half;
    logic [3:0]  pre;
    logic [3:0]  swal;
    logic [11:0] main;
    logic        out;
  } pls_div_type;

  pls_div_type st_reg, st_next;
  logic        pre_edge;
  logic        stage_in;
  logic [3:0]  pre_top;

  always_comb begin
    st_next  = st_reg;
    st_next.out = 1'b0;
    stage_in = in_pulse;
    pre_edge = 1'b0;
    if (dual_mod && pre_half) begin
      stage_in = in_pulse && st_reg.half;
      if (in_pulse) begin
        st_next.half = ~st_reg.half;
      end
    end
    // modulus 16 while swallowing, else 15
    pre_top = (st_reg.swal != 4'h0) ? 4'hF : 4'hE;
    if (!run) begin
      st_next = '0;
    end else if (dual_mod) begin
      if (stage_in) begin
        if (st_reg.pre >= pre_top) begin
          st_next.pre = 4'h0;
          pre_edge = 1'b1;
        end else begin
          st_next.pre = st_reg.pre + 4'h1;
        end
      end
      if (pre_edge) begin
        if (st_reg.swal != 4'h0) begin
          st_next.swal = st_reg.swal - 4'h1;
        end
        if (st_reg.main <= 12'h1) begin
          st_next.main = div_n[15:4];
          st_next.swal = div_n[3:0];
          st_next.out  = 1'b1;
        end else begin
          st_next.main = st_reg.main - 12'h1;
        end
      end
    end else if (stage_in) begin
      // direct division by main counter only
      if (st_reg.main <= 12'h1) begin
        st_next.main = div_n[15:4];
        st_next.out  = 1'b1;
      end else begin
        st_next.main = st_reg.main - 12'h1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign div_out = st_reg.out;

endmodule : pls_prog_div

// *** pls_synth.sv ***
/*
  Synthesizer support block: port decode, reference divider, phase
  comparator, unlock detection and 20-bit IF counter.
  Assumes port strobes and pin inputs are synchronous to ref_clk.
*/
`timescale 1ns/1ps
module pls_synth
  import pls_pkg::*;
#(
  parameter int GATE_CYC_0 = GATE_MS_0 * CYC_PER_MS,
  parameter int GATE_CYC_1 = GATE_MS_1 * CYC_PER_MS,
  parameter int GATE_CYC_2 = GATE_MS_2 * CYC_PER_MS,
  parameter int GATE_CYC_3 = GATE_MS_3 * CYC_PER_MS
)(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  // Port access
  input  wire logic        port_wr,
  input  wire logic        port_rd,
  input  wire logic [3:0]  port_channel_code,
  input  wire logic [3:0]  port_wdata,
  output logic      [3:0]  port_rdata,
  // Divider inputs and pulldowns
  input  wire logic        vhf_divider_input,
  input  wire logic        lf_divider_input,
  output logic             vhf_pulldown,
  output logic             lf_pulldown,
  // Phase comparator outputs
  output logic             phase_out_a,
  output logic             phase_out_a_oe,
  output logic             phase_out_b,
  output logic             phase_out_b_oe,
  // IF inputs and pulldowns
  input  wire logic        if_input_a,
  input  wire logic        if_input_b,
  output logic             if_pulldown_a,
  output logic             if_pulldown_b,
  output logic [1:0]       plain_input_value
);

  typedef struct packed {
    logic [3:0]  mode;
    logic [15:0] div_stage;
    logic [15:0] div_live;
    logic [3:0]  ref_sel;
    logic [1:0]  gate_sel;
    logic        manual;
    logic        busy;
    logic        overflow;
    logic [1:0]  in_ctl;
    logic        if_choice;
    logic [19:0] ref_cnt;
    logic        ref_tick;
    logic        up;
    logic        dn;
    logic        unlock;
    logic        test_en;
    logic [23:0] gate_cnt;
    logic [19:0] if_count_value;
    logic        if_prev;
    logic [3:0]  rdata;
    pls_if_state_type ifst;
  } pls_state_type;

  pls_state_type st_reg, st_next;

  logic        pll_off;
  logic        dual_mod;
  logic        div_out;
  logic [15:0] eff_n;
  logic        div_in;
  logic        if_in;
  logic [23:0] gate_len;

  // ==========================================================
  // Decode helpers
  // ==========================================================
  // gate lengths from parameters
  function automatic logic [23:0] gate_cycles(input logic [1:0] s);
    case (s)
      2'h0:    return 24'(GATE_CYC_0);
      2'h1:    return 24'(GATE_CYC_1);
      2'h2:    return 24'(GATE_CYC_2);
      default: return 24'(GATE_CYC_3);
    endcase
  endfunction : gate_cycles

  function automatic logic wr_hit(input logic w, input logic [3:0] c,
                                  input logic [3:0] want);
    return w && (c == want);
  endfunction : wr_hit

  // all-ones reference code is PLL off
  assign pll_off  = (st_reg.ref_sel == REF_PLL_OFF);
  // both band bits zero selects direct division
  assign dual_mod = st_reg.mode[MODE_HIGH_BAND] || st_reg.mode[MODE_VHF_BAND];
  assign gate_len = gate_cycles(st_reg.gate_sel);

  // offset only in dual-modulus modes, minus wins when both set
  always_comb begin
    eff_n = st_reg.div_live;
    if (dual_mod) begin
      if (st_reg.mode[MODE_OFS_MINUS]) begin
        eff_n = st_reg.div_live - 16'h1;
      end else if (st_reg.mode[MODE_OFS_PLUS]) begin
        eff_n = st_reg.div_live + 16'h1;
      end
    end
  end

  // input follows the vhf band bit; vhf band uses the vhf pin
  assign div_in = st_reg.mode[MODE_VHF_BAND] ? vhf_divider_input : lf_divider_input;
  assign vhf_pulldown = pll_off || !st_reg.mode[MODE_VHF_BAND];
  assign lf_pulldown  = pll_off || st_reg.mode[MODE_VHF_BAND];

  // ==========================================================
  // Programmable divider
  // ==========================================================
  pls_prog_div u_div (
    .ref_clk  (ref_clk),
    .resetn   (resetn),
    .run      (!pll_off),
    .dual_mod (dual_mod),
    .pre_half (st_reg.mode[MODE_HIGH_BAND] && st_reg.mode[MODE_VHF_BAND]),
    .div_n    (eff_n),
    .in_pulse (div_in),
    .div_out  (div_out)
  );

  // IF pin gated by its input-control bit; unselected pin pulled down
  assign if_in = st_reg.if_choice ? (if_input_a && !st_reg.in_ctl[0])
                                  : (if_input_b && !st_reg.in_ctl[1]);
  assign if_pulldown_a = pll_off || !st_reg.if_choice;
  assign if_pulldown_b = pll_off || st_reg.if_choice;
  assign plain_input_value = {if_input_b && st_reg.in_ctl[1], if_input_a && st_reg.in_ctl[0]};

  // ==========================================================
  // Next state
  // ==========================================================
  always_comb begin
    st_next = st_reg;
    st_next.ref_tick = 1'b0;
    st_next.if_prev  = if_in;

    // Port writes
    if (wr_hit(port_wr, port_channel_code, CH_OUT_MODE)) begin
      st_next.mode = port_wdata;
    end
    if (wr_hit(port_wr, port_channel_code, CH_OUT_DIV0)) begin
      st_next.div_stage[3:0] = port_wdata;
    end
    if (wr_hit(port_wr, port_channel_code, CH_OUT_DIV1)) begin
      st_next.div_stage[7:4] = port_wdata;
    end
    if (wr_hit(port_wr, port_channel_code, CH_OUT_DIV2)) begin
      st_next.div_stage[11:8] = port_wdata;
    end
    // whole division number applied with the top nibble
    if (wr_hit(port_wr, port_channel_code, CH_OUT_DIV3)) begin
      st_next.div_stage[15:12] = port_wdata;
      st_next.div_live = {port_wdata, st_reg.div_stage[11:0]};
    end
    if (wr_hit(port_wr, port_channel_code, CH_OUT_REF)) begin
      st_next.ref_sel = port_wdata;
    end

    // reference divider; code-to-ratio table; stopped when off
    if (pll_off || st_reg.ref_sel >= REF_CODES[3:0]) begin
      st_next.ref_cnt = '0;
    end else if (st_reg.ref_cnt + 20'h1 >= pls_ref_half(st_reg.ref_sel) * 20'h2) begin
      st_next.ref_cnt  = '0;
      st_next.ref_tick = 1'b1;
    end else begin
      st_next.ref_cnt = st_reg.ref_cnt + 20'h1;
    end

    // phase-frequency detector, up on reference first, down on divider first
    if (pll_off) begin
      st_next.up = 1'b0;
      st_next.dn = 1'b0;
    end else begin
      if (st_reg.ref_tick && div_out) begin
        st_next.up = 1'b0;
        st_next.dn = 1'b0;
      end else if (st_reg.ref_tick) begin
        st_next.up = !st_reg.dn;
        st_next.dn = 1'b0;
      end else if (div_out) begin
        st_next.dn = !st_reg.up;
        st_next.up = 1'b0;
      end
    end

    if (wr_hit(port_wr, port_channel_code, CH_OUT_IFCTL_B) && port_wdata[CTLB_UNLK_RST]) begin
      st_next.unlock  = 1'b0;
      st_next.test_en = 1'b0;
    end
    // error at a reference edge sets unlock; set wins over clear
    if (st_reg.ref_tick && (st_reg.up || st_reg.dn)) begin
      st_next.unlock = 1'b1;
    end
    // test-enable set at each detection instant
    if (st_reg.ref_tick) begin
      st_next.test_en = 1'b1;
    end

    // IF control nibbles on channels 6 and 7
    if (wr_hit(port_wr, port_channel_code, CH_OUT_IFCTL_B)) begin
      st_next.in_ctl    = port_wdata[CTLB_INCTL_B:CTLB_INCTL_A];
      st_next.if_choice = port_wdata[CTLB_IF_CHOICE];
    end

    case (st_reg.ifst)
      PLS_IDLE, PLS_DONE: begin
        st_next.busy = 1'b0;
      end
      PLS_COUNT: begin
        st_next.gate_cnt = st_reg.gate_cnt + 24'h1;
        if (!st_reg.manual && st_reg.gate_cnt + 24'h1 >= gate_len) begin
          st_next.ifst = PLS_DONE;
          st_next.busy = 1'b0;
        end
        if (if_in && !st_reg.if_prev) begin
          if (st_reg.if_count_value == 20'hFFFFF) begin
            st_next.overflow = 1'b1;
          end
          st_next.if_count_value = st_reg.if_count_value + 20'h1;
        end
      end
      default: st_next.ifst = PLS_IDLE;
    endcase
    if (wr_hit(port_wr, port_channel_code, CH_OUT_IFCTL_A)) begin
      st_next.gate_sel = port_wdata[CTLA_GATE1:CTLA_GATE0];
      st_next.manual   = port_wdata[CTLA_MANUAL];
      if (port_wdata[CTLA_GO]) begin
        st_next.ifst           = PLS_COUNT;
        st_next.busy           = 1'b1;
        st_next.overflow       = 1'b0;
        st_next.gate_cnt       = '0;
        st_next.if_count_value = '0;
      end else if (port_wdata[CTLA_MANUAL]) begin
        st_next.ifst = PLS_DONE;
        st_next.busy = 1'b0;
      end
    end
    // PLL off holds the IF counter in reset
    if (pll_off) begin
      st_next.ifst           = PLS_IDLE;
      st_next.busy           = 1'b0;
      st_next.overflow       = 1'b0;
      st_next.gate_cnt       = '0;
      st_next.if_count_value = '0;
    end

    // count nibbles on channels 1 to 5, status on 6, unlock on 7
    if (port_rd) begin
      case (port_channel_code)
        4'h1:    st_next.rdata = st_reg.if_count_value[3:0];
        4'h2:    st_next.rdata = st_reg.if_count_value[7:4];
        4'h3:    st_next.rdata = st_reg.if_count_value[11:8];
        4'h4:    st_next.rdata = st_reg.if_count_value[15:12];
        CH_IN_CNT4: st_next.rdata = st_reg.if_count_value[19:16];
        CH_IN_STATUS: st_next.rdata = {2'h0, st_reg.overflow, st_reg.busy};
        CH_IN_UNLOCK: st_next.rdata = {st_reg.test_en, st_reg.unlock, plain_input_value};
        default: st_next.rdata = 4'h0;
      endcase
    end
  end

  // ==========================================================
  // State register
  // ==========================================================
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      st_reg           <= '0;
      st_reg.ref_sel   <= REF_RESET;
      st_reg.in_ctl    <= INCTL_RESET;
      st_reg.if_choice <= IF_CH_RESET;
      st_reg.ifst      <= PLS_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  // two parallel tri-state outputs carry the same error
  assign phase_out_a    = st_reg.up;
  assign phase_out_b    = st_reg.up;
  assign phase_out_a_oe = st_reg.up || st_reg.dn;
  assign phase_out_b_oe = st_reg.up || st_reg.dn;
  assign port_rdata     = st_reg.rdata;

  // ==========================================================
  // Assertions
  // ==========================================================
  property p_off_idle;
    @(posedge ref_clk) disable iff (!resetn) pll_off |=> !st_reg.busy && st_reg.if_count_value == '0;
  endproperty
  a_off_idle: assert property (p_off_idle) else $error("IF counter not reset in PLL off");
  property p_off_pd;
    @(posedge ref_clk) disable iff (!resetn) pll_off |-> vhf_pulldown && lf_pulldown;
  endproperty
  a_off_pd: assert property (p_off_pd) else $error("divider inputs not pulled down");
  property p_unlk_clr;
    @(posedge ref_clk) disable iff (!resetn)
      (wr_hit(port_wr, port_channel_code, CH_OUT_IFCTL_B) && port_wdata[CTLB_UNLK_RST] && !st_reg.ref_tick)
      |=> !st_reg.test_en && !st_reg.unlock;
  endproperty
  a_unlk_clr: assert property (p_unlk_clr) else $error("unlock reset ignored");
  property p_unlk_set;
    @(posedge ref_clk) disable iff (!resetn) (st_reg.ref_tick && st_reg.up) |=> st_reg.unlock && st_reg.test_en;
  endproperty
  a_unlk_set: assert property (p_unlk_set) else $error("unlock not set on error");
  property p_go;
    @(posedge ref_clk) disable iff (!resetn)
      (wr_hit(port_wr, port_channel_code, CH_OUT_IFCTL_A) && port_wdata[CTLA_GO] && !pll_off) |=> st_reg.busy;
  endproperty
  a_go: assert property (p_go) else $error("count did not start");
  property p_msb;
    @(posedge ref_clk) disable iff (!resetn)
      wr_hit(port_wr, port_channel_code, CH_OUT_DIV0) |=> $stable(st_reg.div_live);
  endproperty
  a_msb: assert property (p_msb) else $error("divider applied early");
  property p_ref;
    @(posedge ref_clk) disable iff (!resetn)
      wr_hit(port_wr, port_channel_code, CH_OUT_REF) |=> st_reg.ref_sel == $past(port_wdata);
  endproperty
  a_ref: assert property (p_ref) else $error("reference port not written");
  property p_ifpd;
    @(posedge ref_clk) disable iff (!resetn) (if_pulldown_a != if_pulldown_b) || pll_off;
  endproperty
  a_ifpd: assert property (p_ifpd) else $error("IF pulldown wrong");

  c_lock_tick: cover property (@(posedge ref_clk) st_reg.ref_tick && !st_reg.up && !st_reg.dn);
  c_unlock:    cover property (@(posedge ref_clk) $rose(st_reg.unlock));
  c_done:      cover property (@(posedge ref_clk) st_reg.ifst == PLS_DONE);

endmodule : pls_synth

// *** pls_front_model.sv ***
/*
  Far side model: VCO pulses on the divider inputs and IF pulses on the IF pins.
  Assumes ref_clk and the pulldown outputs of the synthesizer block.
*/
`timescale 1ns/1ps
module pls_front_model (
  // Clock
  input  wire logic ref_clk,
  // Bench control
  input  wire logic vco_en,
  input  wire logic if_en,
  // Pulldowns from the block
  input  wire logic vhf_pd,
  input  wire logic lf_pd,
  input  wire logic if_pd_a,
  input  wire logic if_pd_b,
  // Pin levels
  output logic      vhf_in,
  output logic      lf_in,
  output logic      if_a,
  output logic      if_b
);
  logic ph_reg = 1'b0;
  always @(negedge ref_clk) begin
    ph_reg <= ~ph_reg;
  end
  assign vhf_in = vco_en & ph_reg & ~vhf_pd;
  assign lf_in  = vco_en & ph_reg & ~lf_pd;
  assign if_a   = if_en & ph_reg & ~if_pd_a;
  assign if_b   = if_en & ph_reg & ~if_pd_b;
endmodule : pls_front_model

// *** test_pls_synth.sv ***
/*
  Self-checking bench for the synthesizer block with the far side model.
  Assumes short gate counts of 20, 40, 60 and 80 cycles.
*/
`timescale 1ns/1ps
module test_pls_synth;
  import pls_pkg::*;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic port_wr = 1'b0;
  logic port_rd = 1'b0;
  logic [3:0] ch = 4'h0;
  logic [3:0] wd = 4'h0;
  logic [3:0] port_rdata;
  logic vco_en = 1'b0;
  logic if_en = 1'b0;
  logic vhf_in, lf_in, if_a, if_b, vhf_pd, lf_pd, pd_a, pd_b;
  logic [1:0] plain;
  logic pa, pa_oe, pb, pb_oe;
  int mdl_cnt = 0;
  int mdl_gate = 0;
  logic mdl_prev = 1'b0;
  logic [7:0] lfsr = 8'h04;
  int error_cnt = 0;
  int tests_run = 0;
  `define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin error_cnt++; \
    $display("mismatch at %0t: got %h want %h", $time, (a), (b)); end end
  always #5 ref_clk = ~ref_clk;
  // Reference model: rising edges of IF pin a inside the gate window
  always @(posedge ref_clk) begin
    if (mdl_gate > 0) begin
      mdl_gate <= mdl_gate - 1;
      if (if_a && !mdl_prev) begin
        mdl_cnt <= mdl_cnt + 1;
      end
    end
    mdl_prev <= if_a;
  end
  pls_synth #(.GATE_CYC_0(20), .GATE_CYC_1(40), .GATE_CYC_2(60), .GATE_CYC_3(80)) pls_synth_i (
    .ref_clk(ref_clk), .resetn(resetn), .port_wr(port_wr), .port_rd(port_rd),
    .port_channel_code(ch), .port_wdata(wd), .port_rdata(port_rdata),
    .vhf_divider_input(vhf_in), .lf_divider_input(lf_in), .vhf_pulldown(vhf_pd), .lf_pulldown(lf_pd),
    .phase_out_a(pa), .phase_out_a_oe(pa_oe), .phase_out_b(pb), .phase_out_b_oe(pb_oe),
    .if_input_a(if_a), .if_input_b(if_b), .if_pulldown_a(pd_a), .if_pulldown_b(pd_b),
    .plain_input_value(plain));
  pls_front_model pls_front_model_i (
    .ref_clk(ref_clk), .vco_en(vco_en), .if_en(if_en), .vhf_pd(vhf_pd), .lf_pd(lf_pd),
    .if_pd_a(pd_a), .if_pd_b(pd_b), .vhf_in(vhf_in), .lf_in(lf_in), .if_a(if_a), .if_b(if_b));
  // ==========================================================
  // Tasks
  // ==========================================================
  function automatic logic [7:0] lfsr_next();
    lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
    return lfsr;
  endfunction : lfsr_next
  task automatic wr(input logic [3:0] c, input logic [3:0] d);
    ch = c;
    wd = d;
    port_wr = 1'b1;
    @(negedge ref_clk);
    port_wr = 1'b0;
    @(negedge ref_clk);
  endtask : wr
  task automatic rd(input logic [3:0] c, output logic [3:0] d);
    ch = c;
    port_rd = 1'b1;
    @(negedge ref_clk);
    port_rd = 1'b0;
    @(negedge ref_clk);
    d = port_rdata;
  endtask : rd
  task automatic rd_count(output logic [19:0] c);
    logic [3:0] d;
    for (int k = 0; k < 5; k++) begin
      rd(CH_IN_CNT0 + 4'(k), d);
      c[4*k +: 4] = d;
    end
  endtask : rd_count
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : complete_run
  // ==========================================================
  // Main sequence
  // ==========================================================
  initial begin : main
    logic [3:0] d;
    logic [19:0] c;
    logic [3:0] modes [4];
    int n;
    modes = '{4'h0, 4'h1, 4'h8, 4'h9};
    repeat (16) @(negedge ref_clk);
    resetn = 1'b1;
    `CHK({vhf_pd, lf_pd, pd_a, pd_b}, 4'hF)
    rd(CH_IN_UNLOCK, d);
    `CHK(d[1:0], 2'h0)
    wr(CH_OUT_REF, 4'h3);
    `CHK({pd_a, pd_b}, 2'h1)
    foreach (modes[i]) begin
      wr(CH_OUT_MODE, modes[i]);
      wr(CH_OUT_DIV0, 4'(lfsr_next()));
      wr(CH_OUT_DIV1, 4'(lfsr_next()));
      wr(CH_OUT_DIV2, 4'(lfsr_next()));
      wr(CH_OUT_DIV3, 4'h1);
      `CHK({vhf_pd, lf_pd}, {~modes[i][3], modes[i][3]})
    end
    wr(CH_OUT_MODE, 4'h0);
    repeat (2500) @(negedge ref_clk);
    rd(CH_IN_UNLOCK, d);
    `CHK(d[3:2], 2'h3)
    `CHK({pa, pa_oe, pb, pb_oe}, 4'hF)
    wr(CH_OUT_IFCTL_B, 4'hC);
    rd(CH_IN_UNLOCK, d);
    `CHK(d[3:2], 2'h0)
    // direct n = 500 on a half-rate input matches the 100 kHz reference
    wr(CH_OUT_DIV0, 4'h0);
    wr(CH_OUT_DIV1, 4'h4);
    wr(CH_OUT_DIV2, 4'hF);
    wr(CH_OUT_DIV3, 4'h1);
    vco_en = 1'b1;
    repeat (2500) @(negedge ref_clk);
    wr(CH_OUT_IFCTL_B, 4'hC);
    repeat (1500) @(negedge ref_clk);
    rd(CH_IN_UNLOCK, d);
    `CHK(d[3:2], 2'h2)
    n = int'(lfsr_next() % 60) + 1;
    wr(CH_OUT_IFCTL_A, 4'hC);
    if_en = 1'b1;
    repeat (2 * n) @(negedge ref_clk);
    if_en = 1'b0;
    repeat (4) @(negedge ref_clk);
    wr(CH_OUT_IFCTL_A, 4'h4);
    rd_count(c);
    `CHK(c, 20'(n))
    rd(CH_IN_STATUS, d);
    `CHK(d[1:0], 2'h0)
    // Model window: start edge plus the 40-cycle gate
    mdl_cnt = 0;
    mdl_gate = 41;
    wr(CH_OUT_IFCTL_A, 4'h9);
    if_en = 1'b1;
    rd(CH_IN_STATUS, d);
    `CHK(d[0], 1'b1)
    repeat (100) @(negedge ref_clk);
    if_en = 1'b0;
    rd(CH_IN_STATUS, d);
    `CHK(d[0], 1'b0)
    rd_count(c);
    `CHK(c >= 20'd19 && c <= 20'd21, 1'b1)
    `CHK(c, 20'(mdl_cnt))
    wr(CH_OUT_IFCTL_B, 4'h5);
    `CHK(plain[1], 1'b0)
    if_en = 1'b1;
    wr(CH_OUT_IFCTL_A, 4'hC);
    repeat (9) @(negedge ref_clk);
    `CHK(plain[0], if_a)
    @(negedge ref_clk);
    `CHK(plain[0], if_a)
    rd_count(c);
    `CHK(c, 20'h00000)
    wr(CH_OUT_IFCTL_B, 4'h4);
    repeat (8) @(negedge ref_clk);
    rd_count(c);
    `CHK(c != 20'h00000, 1'b1)
    wr(CH_OUT_REF, REF_PLL_OFF);
    if_en = 1'b0;
    rd_count(c);
    `CHK(c, 20'h00000)
    rd(CH_IN_STATUS, d);
    `CHK(d[0], 1'b0)
    `CHK({vhf_pd, lf_pd}, 2'h3)
    `CHK({pa_oe, pb_oe}, 2'h0)
    complete_run();
  end
  initial begin : watchdog
    #500us;
    error_cnt++;
    complete_run();
  end
endmodule : test_pls_synth
